/* File: common/dsc_pkg.sv */
// Shared constants for the safemode capture digital I/O block
`default_nettype none

package dsc_pkg;

    // ----------------------------------------------------------------
    // Channel organisation
    // ----------------------------------------------------------------
    localparam int NCH = 48;
    localparam int GRP = 24;
    localparam int ADDR_W = 10;

    // ----------------------------------------------------------------
    // Register byte offsets (channel registers: group 0 at offset, group 1 at offset + 4; CTRL and STATUS are single)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_OUT = 8'h00;
    localparam logic [7:0] OFS_SAFE_DATA = 8'h08;
    localparam logic [7:0] OFS_SAFE_EN = 8'h10;
    localparam logic [7:0] OFS_CAP_RISE = 8'h18;
    localparam logic [7:0] OFS_CAP_FALL = 8'h20;
    localparam logic [7:0] OFS_SRC_SEL = 8'h28;
    localparam logic [7:0] OFS_FILT_EN = 8'h30;
    localparam logic [7:0] OFS_PIN = 8'h38;
    localparam logic [7:0] OFS_CAP_FLAG = 8'h40;
    localparam logic [7:0] OFS_CTRL = 8'h48;
    localparam logic [7:0] OFS_STATUS = 8'h4c;

    // ----------------------------------------------------------------
    // Write mode field in haddr[9:8]
    // ----------------------------------------------------------------
    localparam int MODE_LSB = 8;
    localparam logic [1:0] MODE_WRITE = 2'h0;
    localparam logic [1:0] MODE_CLEAR = 2'h1;
    localparam logic [1:0] MODE_SET = 2'h2;

    // ----------------------------------------------------------------
    // Control and status fields
    // ----------------------------------------------------------------
    localparam int CTRL_SWE_BIT = 0;
    localparam int CTRL_FILT_T_LSB = 8;
    localparam int FILT_T_W = 8;
    localparam int STATUS_SAFE_BIT = 0;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [NCH-1:0] RST_CHAN_ZERO = 48'h0000_0000_0000;
    localparam logic [NCH-1:0] RST_SAFE_EN = 48'hffff_ffff_ffff;
    localparam logic [FILT_T_W-1:0] RST_FILT_T = 8'h00;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int SAMPLE_PERIOD_NS = 20;
    localparam int MIN_INPUT_HOLD_NS = 20;
    localparam int SAMPLE_DIV = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

endpackage : dsc_pkg

`default_nettype wire

/* File: src/dsc_dio.sv */
// Safemode capture digital I/O block with AHB-Lite register slave
`timescale 1ns/100ps
`default_nettype none

module dsc_dio
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [dsc_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic safemode_request,
    input wire logic [dsc_pkg::NCH-1:0] counter_external_output,
    output logic [dsc_pkg::NCH-1:0] counter_external_input,
    input wire logic [dsc_pkg::NCH-1:0] pin_in,
    output logic [dsc_pkg::NCH-1:0] pin_out,
    output logic [dsc_pkg::NCH-1:0] pin_oe
);

    // ----------------------------------------------------------------
    // Write mode helper
    // ----------------------------------------------------------------
    function automatic logic [23:0] dsc_apply(
        input logic [23:0] old,
        input logic [23:0] d,
        input logic [1:0] m
    );
        logic [23:0] r;
        r = old;
        case (m)
            dsc_pkg::MODE_WRITE: r = d;
            dsc_pkg::MODE_CLEAR: r = old & ~d;
            dsc_pkg::MODE_SET: r = old | d;
            default: r = old;
        endcase
        return r;
    endfunction : dsc_apply

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [dsc_pkg::NCH-1:0] out_reg;
    logic [dsc_pkg::NCH-1:0] safe_data;
    logic [dsc_pkg::NCH-1:0] safe_en;
    logic [dsc_pkg::NCH-1:0] cap_rise;
    logic [dsc_pkg::NCH-1:0] cap_fall;
    logic [dsc_pkg::NCH-1:0] src_sel;
    logic [dsc_pkg::NCH-1:0] filt_en;
    logic [dsc_pkg::NCH-1:0] cap_flag;
    logic [dsc_pkg::NCH-1:0] cap_clr;
    logic [dsc_pkg::NCH-1:0] cap_set;
    logic [dsc_pkg::NCH-1:0] sampled;
    logic [dsc_pkg::NCH-1:0] filt_prev;
    logic [dsc_pkg::NCH-1:0] next_drive;
    logic safe_write_enable;
    logic [dsc_pkg::FILT_T_W-1:0] filt_time;
    logic safe_active;
    logic [2:0] div_cnt;
    logic tick;

    logic acc;
    logic rd_acc;
    logic wr_q;
    logic [dsc_pkg::ADDR_W-1:0] addr_q;
    logic [4:0] wr_slot;
    logic [1:0] wr_mode;
    logic [31:0] next_rdata;

    // ----------------------------------------------------------------
    // Sample rate divider
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_cnt <= 3'h0;
            tick <= 1'b0;
        end
        else if (div_cnt == 3'(dsc_pkg::SAMPLE_DIV - 1))
        begin
            div_cnt <= 3'h0;
            tick <= 1'b1;
        end
        else
        begin
            div_cnt <= div_cnt + 3'h1;
            tick <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Bus address phase
    // ----------------------------------------------------------------
    assign acc = hsel & htrans[1] & hready;
    assign rd_acc = acc & ~hwrite;
    assign wr_slot = addr_q[7:3];
    assign wr_mode = addr_q[dsc_pkg::MODE_LSB +: 2];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            addr_q <= '0;
        end
        else if (hready)
        begin
            wr_q <= acc & hwrite;
            addr_q <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Read data mux
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [47:0] v;
        logic g;
        v = '0;
        g = haddr[2];
        next_rdata = '0;
        unique case (haddr[7:3])
            dsc_pkg::OFS_OUT[7:3]: v = out_reg;
            dsc_pkg::OFS_SAFE_DATA[7:3]: v = safe_data;
            dsc_pkg::OFS_SAFE_EN[7:3]: v = safe_en;
            dsc_pkg::OFS_CAP_RISE[7:3]: v = cap_rise;
            dsc_pkg::OFS_CAP_FALL[7:3]: v = cap_fall;
            dsc_pkg::OFS_SRC_SEL[7:3]: v = src_sel;
            dsc_pkg::OFS_FILT_EN[7:3]: v = filt_en;
            dsc_pkg::OFS_PIN[7:3]: v = counter_external_input;
            dsc_pkg::OFS_CAP_FLAG[7:3]: v = cap_flag;
            default: v = '0;
        endcase
        next_rdata[23:0] = g ? v[47:24] : v[23:0];
        if (haddr[7:2] == dsc_pkg::OFS_CTRL[7:2])
        begin
            next_rdata = '0;
            next_rdata[dsc_pkg::CTRL_SWE_BIT] = safe_write_enable;
            next_rdata[dsc_pkg::CTRL_FILT_T_LSB +: dsc_pkg::FILT_T_W] =
                filt_time;
        end
        else if (haddr[7:2] == dsc_pkg::OFS_STATUS[7:2])
        begin
            next_rdata = '0;
            next_rdata[dsc_pkg::STATUS_SAFE_BIT] = safe_active;
        end
        else if (haddr[7:3] > dsc_pkg::OFS_CAP_FLAG[7:3])
        begin
            next_rdata = '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if (rd_acc)
        begin
            hrdata <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            safe_write_enable <= 1'b0;
            filt_time <= dsc_pkg::RST_FILT_T;
        end
        else if (wr_q && addr_q[7:2] == dsc_pkg::OFS_CTRL[7:2])
        begin
            safe_write_enable <= hwdata[dsc_pkg::CTRL_SWE_BIT];
            filt_time <= hwdata[dsc_pkg::CTRL_FILT_T_LSB +: dsc_pkg::FILT_T_W];
        end
    end

    // ----------------------------------------------------------------
    // Per-group channel registers
    // ----------------------------------------------------------------
    for (genvar g = 0; g < 2; g++)
    begin : g_grp
        logic hit;
        logic [23:0] d;
        assign hit = wr_q & (addr_q[2] == 1'(g));
        assign d = hwdata[23:0];

        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                out_reg[g*24 +: 24] <= dsc_pkg::RST_CHAN_ZERO[g*24 +: 24];
            end
            else if (hit && wr_slot == dsc_pkg::OFS_OUT[7:3])
            begin
                out_reg[g*24 +: 24] <= dsc_apply(out_reg[g*24 +: 24], d,
                    wr_mode);
            end
        end

        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                safe_data[g*24 +: 24] <= dsc_pkg::RST_CHAN_ZERO[g*24 +: 24];
                safe_en[g*24 +: 24] <= dsc_pkg::RST_SAFE_EN[g*24 +: 24];
            end
            else if (hit && safe_write_enable)
            begin
                if (wr_slot == dsc_pkg::OFS_SAFE_DATA[7:3])
                begin
                    safe_data[g*24 +: 24] <= dsc_apply(safe_data[g*24 +: 24],
                        d, wr_mode);
                end
                if (wr_slot == dsc_pkg::OFS_SAFE_EN[7:3])
                begin
                    safe_en[g*24 +: 24] <= d;
                end
            end
        end

        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                cap_rise[g*24 +: 24] <= dsc_pkg::RST_CHAN_ZERO[g*24 +: 24];
                cap_fall[g*24 +: 24] <= dsc_pkg::RST_CHAN_ZERO[g*24 +: 24];
            end
            else if (hit)
            begin
                if (wr_slot == dsc_pkg::OFS_CAP_RISE[7:3])
                begin
                    cap_rise[g*24 +: 24] <= dsc_apply(cap_rise[g*24 +: 24],
                        d, wr_mode);
                end
                if (wr_slot == dsc_pkg::OFS_CAP_FALL[7:3])
                begin
                    cap_fall[g*24 +: 24] <= dsc_apply(cap_fall[g*24 +: 24],
                        d, wr_mode);
                end
            end
        end

        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                src_sel[g*24 +: 24] <= dsc_pkg::RST_CHAN_ZERO[g*24 +: 24];
                filt_en[g*24 +: 24] <= dsc_pkg::RST_CHAN_ZERO[g*24 +: 24];
            end
            else if (hit)
            begin
                if (wr_slot == dsc_pkg::OFS_SRC_SEL[7:3])
                begin
                    src_sel[g*24 +: 24] <= dsc_apply(src_sel[g*24 +: 24], d,
                        wr_mode);
                end
                if (wr_slot == dsc_pkg::OFS_FILT_EN[7:3])
                begin
                    filt_en[g*24 +: 24] <= dsc_apply(filt_en[g*24 +: 24], d,
                        wr_mode);
                end
            end
        end

        // Flags read in this address phase are cleared
        assign cap_clr[g*24 +: 24] =
            (rd_acc && haddr[7:3] == dsc_pkg::OFS_CAP_FLAG[7:3] &&
            haddr[2] == 1'(g)) ? cap_flag[g*24 +: 24] : 24'h00_0000;
    end

    // ----------------------------------------------------------------
    // Pin sampling and noise filter
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sampled <= dsc_pkg::RST_CHAN_ZERO;
        end
        else if (tick)
        begin
            sampled <= ~pin_in;
        end
    end

    for (genvar i = 0; i < dsc_pkg::NCH; i++)
    begin : g_filt
        logic [dsc_pkg::FILT_T_W-1:0] cnt;
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                cnt <= '0;
                counter_external_input[i] <= 1'b0;
            end
            else if (tick)
            begin
                if (sampled[i] == counter_external_input[i])
                begin
                    cnt <= '0;
                end
                else if (!filt_en[i] || cnt + 8'h01 >= filt_time)
                begin
                    cnt <= '0;
                    counter_external_input[i] <= sampled[i];
                end
                else
                begin
                    cnt <= cnt + 8'h01;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Edge capture
    // ----------------------------------------------------------------
    assign cap_set = (counter_external_input & ~filt_prev & cap_fall) |
        (~counter_external_input & filt_prev & cap_rise);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            filt_prev <= dsc_pkg::RST_CHAN_ZERO;
            cap_flag <= dsc_pkg::RST_CHAN_ZERO;
        end
        else
        begin
            filt_prev <= counter_external_input;
            cap_flag <= (cap_flag & ~cap_clr) | cap_set;
        end
    end

    // ----------------------------------------------------------------
    // Safemode and pin drive
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            safe_active <= 1'b0;
        end
        else
        begin
            safe_active <= safemode_request;
        end
    end

    always_comb
    begin
        next_drive = (src_sel & counter_external_output) |
            (~src_sel & out_reg);
        if (safe_active)
        begin
            next_drive = (safe_en & safe_data) | (~safe_en & next_drive);
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_oe <= dsc_pkg::RST_CHAN_ZERO;
            pin_out <= dsc_pkg::RST_CHAN_ZERO;
        end
        else if (tick)
        begin
            pin_oe <= next_drive;
            pin_out <= dsc_pkg::RST_CHAN_ZERO;
        end
    end

endmodule : dsc_dio

`default_nettype wire

/* File: tb/dsc_dio_chk.sv */
// Assertion checker bound to the digital I/O block
`timescale 1ns/100ps
`default_nettype none

module dsc_chk
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [dsc_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [dsc_pkg::NCH-1:0] counter_external_input,
    input wire logic [dsc_pkg::NCH-1:0] pin_out,
    input wire logic [dsc_pkg::NCH-1:0] pin_oe
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence rd_acc;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence pin_rd;
        rd_acc ##0 haddr[7:0] == dsc_pkg::OFS_PIN;
    endsequence

    drive_open_a: assert property (pin_out == 48'h0)
        else $error("pin_out driven high");
    oe_hold_a: assert property (
        $changed(pin_oe) |=> $stable(pin_oe) [*4])
        else $error("pin_oe changed within a sample period");
    in_hold_a: assert property (
        $changed(counter_external_input) |=>
        $stable(counter_external_input) [*4])
        else $error("input sample changed within a sample period");
    ready_up_a: assert property ($past(hresetn) |-> hreadyout)
        else $error("hreadyout low after reset");
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("hresp not OKAY");
    high_zero_a: assert property (
        rd_acc |=> hrdata[31:24] == 8'h00)
        else $error("unused read bits not zero");
    unmapped_zero_a: assert property (
        rd_acc ##0 haddr[7:0] > 8'h4f |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    pin_read_a: assert property (
        pin_rd ##0 !haddr[2] |=>
        hrdata[23:0] == $past(counter_external_input[23:0]) ||
        hrdata[23:0] == counter_external_input[23:0])
        else $error("pin read differs from sampled state");
    reset_clear_a: assert property (
        $rose(hresetn) |-> pin_oe == 48'h0 ##1 hreadyout)
        else $error("outputs not clear after reset");
endmodule : dsc_chk

bind dsc_dio dsc_chk i_dsc_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hready, .hreadyout, .hresp, .hrdata, .counter_external_input,
    .pin_out, .pin_oe);

`default_nettype wire

/* File: tb/dsc_pins.sv */
// Open-drain pins with pull-ups and external pull-down sources
`timescale 1ns/100ps
`default_nettype none

module dsc_pins
(
    input wire logic [dsc_pkg::NCH-1:0] pin_oe,
    input wire logic [dsc_pkg::NCH-1:0] pin_out,
    input wire logic [dsc_pkg::NCH-1:0] ext_low,
    output logic [dsc_pkg::NCH-1:0] pin_in
);
    // Caller holds ext_low five hclk or more per change
    // Released line rises through its pull-up
    assign pin_in = ~((pin_oe & ~pin_out) | ext_low);
endmodule : dsc_pins

`default_nettype wire

/* File: tb/digital_io_safemode_capture_bench.sv */
// Self-checking bench for the digital I/O block
`timescale 1ns/100ps
`default_nettype none

module digital_io_safemode_capture_bench;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic safemode_request;
    logic [dsc_pkg::ADDR_W-1:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd, d;
    logic [47:0] ceo, cei, pin_in, pin_out, pin_oe, ext_low;
    logic [23:0] m_out[2], m_sd[2], m_se[2], m_src[2];
    int num_errors, checked, seed;

    assign hready = hreadyout;
    dsc_dio i_dsc_dio (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
        .safemode_request, .counter_external_output(ceo),
        .counter_external_input(cei), .pin_in, .pin_out, .pin_oe);
    dsc_pins i_dsc_pins (.pin_oe, .pin_out, .ext_low, .pin_in);

    initial
    begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    task automatic summarize;
        $display("num_errors=%0d checked=%0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_rdy;
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hready !== 1'b1 && n < 100);
        if (hready !== 1'b1)
        begin
            num_errors++;
            summarize();
        end
    endtask : wait_rdy

    task automatic bus(input logic [9:0] a, input logic w,
        input logic [31:0] x);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= x;
        wait_rdy();
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] o, input int g, input int m,
        input logic [31:0] x);
        bus({2'(m), o + 8'(4 * g)}, 1'b1, x);
    endtask : wr

    task automatic rdr(input logic [7:0] o, input int g);
        bus({2'h0, o + 8'(4 * g)}, 1'b0, 32'h0);
    endtask : rdr

    function automatic logic [23:0] upd(logic [23:0] o, logic [23:0] x, int m);
        return m == 0 ? x : m == 1 ? o & ~x : m == 2 ? o | x : o;
    endfunction : upd

    function automatic logic [23:0] eoe(int g);
        logic [23:0] run;
        run = (m_src[g] & ceo[24 * g +: 24]) | (~m_src[g] & m_out[g]);
        if (safemode_request)
            run = (m_se[g] & m_sd[g]) | (~m_se[g] & run);
        return run;
    endfunction : eoe

    task automatic oe_cmp;
        repeat (12) @(posedge hclk);
        for (int g = 0; g < 2; g++)
            check(32'(pin_oe[24*g +: 24]), 32'(eoe(g)));
    endtask : oe_cmp

    task automatic flags(input logic [23:0] exp);
        repeat (12) @(posedge hclk);
        rdr(dsc_pkg::OFS_CAP_FLAG, 0);
        check(rd, {8'h0, exp});
    endtask : flags

    initial
    begin
        repeat (100000) @(posedge hclk);
        num_errors++;
        summarize();
    end

    initial
    begin
        seed = 32'he619;
        num_errors = 0;
        checked = 0;
        {hresetn, hsel, hwrite, safemode_request} = 4'h0;
        haddr = 10'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        ceo = 48'h0;
        ext_low = 48'h0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        // ------------------------------------------------------------
        // Reset values and unmapped space
        // ------------------------------------------------------------
        for (int g = 0; g < 2; g++)
        begin
            m_out[g] = 24'h0;
            m_sd[g] = 24'h0;
            m_se[g] = 24'hffffff;
            m_src[g] = 24'h0;
            for (int k = 0; k < 9; k++)
            begin
                rdr(8'(8 * k), g);
                check(rd, k == 2 ? 32'h00ffffff : 32'h0);
            end
        end
        wr(8'h50, 0, 0, 32'hffffffff);
        rdr(8'h50, 0);
        check(rd, 32'h0);
        // ------------------------------------------------------------
        // Output write modes, drive and pin reads
        // ------------------------------------------------------------
        for (int m = 0; m < 4; m++)
            for (int g = 0; g < 2; g++)
            begin
                d = $random(seed);
                wr(dsc_pkg::OFS_OUT, g, m, d);
                m_out[g] = upd(m_out[g], d[23:0], m);
                rdr(dsc_pkg::OFS_OUT, g);
                check(rd, {8'h0, m_out[g]});
            end
        oe_cmp();
        ext_low <= 48'({$random(seed), $random(seed)});
        repeat (12) @(posedge hclk);
        for (int g = 0; g < 2; g++)
        begin
            d = {8'h0, m_out[g] | ext_low[24 * g +: 24]};
            rdr(dsc_pkg::OFS_PIN, g);
            check(rd, d);
            check(32'(cei[24*g +: 24]), d);
        end
        ext_low <= 48'h0;
        // ------------------------------------------------------------
        // Safe write enable, source select and safemode
        // ------------------------------------------------------------
        wr(dsc_pkg::OFS_SAFE_DATA, 0, 0, 32'h00ffffff);
        wr(dsc_pkg::OFS_SAFE_EN, 0, 0, 32'h0);
        rdr(dsc_pkg::OFS_SAFE_DATA, 0);
        check(rd, 32'h0);
        rdr(dsc_pkg::OFS_SAFE_EN, 0);
        check(rd, 32'h00ffffff);
        wr(dsc_pkg::OFS_CTRL, 0, 0, 32'h1);
        ceo <= 48'({$random(seed), $random(seed)});
        for (int g = 0; g < 2; g++)
        begin
            d = $random(seed);
            wr(dsc_pkg::OFS_SAFE_DATA, g, 0, d);
            m_sd[g] = d[23:0];
            rdr(dsc_pkg::OFS_SAFE_DATA, g);
            check(rd, {8'h0, m_sd[g]});
            d = $random(seed);
            wr(dsc_pkg::OFS_SAFE_EN, g, 0, d);
            m_se[g] = d[23:0];
            d = $random(seed);
            wr(dsc_pkg::OFS_SRC_SEL, g, 0, d);
            m_src[g] = d[23:0];
        end
        oe_cmp();
        safemode_request <= 1'b1;
        oe_cmp();
        rdr(dsc_pkg::OFS_STATUS, 0);
        check(rd, 32'h1);
        safemode_request <= 1'b0;
        for (int g = 0; g < 2; g++)
        begin
            wr(dsc_pkg::OFS_SRC_SEL, g, 0, 32'h0);
            wr(dsc_pkg::OFS_OUT, g, 0, 32'h0);
            m_src[g] = 24'h0;
            m_out[g] = 24'h0;
        end
        oe_cmp();
        // ------------------------------------------------------------
        // Edge capture, read clear and lost edges
        // ------------------------------------------------------------
        wr(dsc_pkg::OFS_CAP_RISE, 0, 0, 32'h5);
        wr(dsc_pkg::OFS_CAP_FALL, 0, 0, 32'h6);
        ext_low <= 48'hf;
        flags(24'h6);
        flags(24'h0);
        ext_low <= 48'h0;
        repeat (12) @(posedge hclk);
        ext_low <= 48'h6;
        repeat (12) @(posedge hclk);
        ext_low <= 48'h0;
        flags(24'h7);
        flags(24'h0);
        // ------------------------------------------------------------
        // Noise filter with four sample periods
        // ------------------------------------------------------------
        wr(dsc_pkg::OFS_CTRL, 0, 0, 32'h0401);
        wr(dsc_pkg::OFS_FILT_EN, 0, 0, 32'h10);
        wr(dsc_pkg::OFS_CAP_FALL, 0, 2, 32'h10);
        ext_low <= 48'h10;
        repeat (10) @(posedge hclk);
        ext_low <= 48'h0;
        repeat (30) @(posedge hclk);
        flags(24'h0);
        ext_low <= 48'h10;
        repeat (30) @(posedge hclk);
        flags(24'h10);
        // ------------------------------------------------------------
        // Second reset
        // ------------------------------------------------------------
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rdr(dsc_pkg::OFS_SAFE_EN, 1);
        check(rd, 32'h00ffffff);
        rdr(dsc_pkg::OFS_CAP_FALL, 0);
        check(rd, 32'h0);
        summarize();
    end
endmodule : digital_io_safemode_capture_bench

`default_nettype wire
